/* File: verilog/mission_status_consts.svh */
// Constants of the mission status register bank
// Assumes inclusion by bare name from each design file that uses its macros
`ifndef MISSION_STATUS_CONSTS_SVH
`define MISSION_STATUS_CONSTS_SVH
`define ADDR_ALARM_FLAGS    10'h214
`define ADDR_GENERAL_STATUS 10'h215
`define ADDR_DELAY_LOW      10'h216
`define ADDR_DELAY_MID      10'h217
`define ADDR_DELAY_HIGH     10'h218
`define ADDR_STAMP_SECONDS  10'h219
`define ADDR_STAMP_MINUTES  10'h21a
`define ADDR_STAMP_HOURS    10'h21b
`define ADDR_STAMP_DATE     10'h21c
`define ADDR_STAMP_MONTH    10'h21d
`define ADDR_STAMP_YEAR     10'h21e
`define ALARM_FIXED_MASK    8'h7C
`define ALARM_FIXED_VALUE   8'h70
`define STATUS_FIXED_MASK   8'hE5
`define STATUS_FIXED_VALUE  8'hC0
`define BIT_LOW_ALARM       0
`define BIT_HIGH_ALARM      1
`define BIT_POWER_LOSS      7
`define BIT_MISSION_ACTIVE  1
`define BIT_MEMORY_CLEARED  3
`define BIT_AWAITING_ALARM  4
`define BIT_TWELVE_HOUR     6
`define BIT_AM_PM           5
`define BIT_CENTURY         7
`define MASK_SECONDS        8'h7F
`define MASK_MINUTES        8'h7F
`define MASK_HOURS          8'h7F
`define MASK_DATE           8'h3F
`define MASK_MONTH          8'h9F
`define MASK_YEAR           8'hFF
`define RESET_POWER_LOSS    1'b1
`define RESET_DELAY         24'h00_0000
`define DELAY_MAX           24'hFF_FFFF
`endif

/* File: verilog/mission_status_pkg.sv */
// Types shared by the mission status register bank
// Assumes the constants header supplies every address, mask and bit number
`default_nettype none
package mission_status_pkg;
    typedef enum logic [1:0] {
        IDLE       = 2'b00,
        DELAY      = 2'b01,
        WAIT_ALARM = 2'b10,
        LOGGING    = 2'b11
    } mode_type;
    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } stamp_type;
    typedef struct packed {
        logic [23:0] count;
    } delay_state_type;
    typedef struct packed {
        mode_type    mode;
        logic        lowAlarm;
        logic        highAlarm;
        logic        powerLoss;
        logic        missionActive;
        logic        memoryCleared;
        logic        awaitingAlarm;
        logic        alarmMode;
        logic        firstDone;
        stamp_type   stamp;
        logic [23:0] sampleCount;
        logic [7:0]  readData;
        logic        readValid;
        logic        convRequest;
        logic        testConversion;
        logic        startRefused;
    } status_state_type;
endpackage : mission_status_pkg
`default_nettype wire

/* File: verilog/alarm_compare.sv */
// Threshold comparator for one temperature reading
// Assumes temperature and thresholds share one monotonic code
`timescale 1ns/10ps
`default_nettype none
module alarm_compare (
    // Reading and thresholds
    input  wire logic [7:0] temperature,
    input  wire logic [7:0] lowThreshold,
    input  wire logic [7:0] highThreshold,
    // Results
    output logic            isLow,
    output logic            isHigh
);
    always_comb
    begin
        isLow  = temperature <= lowThreshold;
        isHigh = temperature >= highThreshold;
    end
endmodule : alarm_compare
`default_nettype wire

/* File: verilog/start_delay_counter.sv */
// Mission start delay store and down counter
// Assumes writes come only while no mission runs
`timescale 1ns/10ps
`default_nettype none
`include "mission_status_consts.svh"
module start_delay_counter (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Byte writes and countdown
    input  wire logic        writeEn,
    input  wire logic [1:0]  byteSel,
    input  wire logic [7:0]  writeData,
    input  wire logic        decrement,
    // Value
    output logic [23:0]      value,
    output logic             isZero
);
    mission_status_pkg::delay_state_type s_q;
    mission_status_pkg::delay_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        if (writeEn)
        begin
            // Lowest address holds the low byte
            case (byteSel)
                2'h0:    s_d.count[7:0]   = writeData;
                2'h1:    s_d.count[15:8]  = writeData;
                2'h2:    s_d.count[23:16] = writeData;
                default: s_d.count        = s_q.count;
            endcase
        end
        else if (decrement && s_q.count != 24'h00_0000)
        begin
            s_d.count = s_q.count - 24'h00_0001;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            s_q <= '{count: `RESET_DELAY};
        else if (ce)
            s_q <= s_d;
    end

    assign value  = s_q.count;
    assign isZero = s_q.count == 24'h00_0000;
endmodule : start_delay_counter
`default_nettype wire

/* File: verilog/mission_status_registers.sv */
// Mission status registers: alarm flags, general status, start delay, stamp
// Assumes commands and conversions arrive as one-cycle strobes from the
// command decoder; reset is the battery power-on reset
`timescale 1ns/10ps
`default_nettype none
`include "mission_status_consts.svh"
module mission_status_registers (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          ce,
    // Register port
    input  wire logic [9:0]                    address,
    input  wire logic                          readStrobe,
    input  wire logic                          writeStrobe,
    input  wire logic [7:0]                    writeData,
    output logic [7:0]                         readData_q,
    output logic                               readValid_q,
    // Mission commands
    input  wire logic                          clearMemory,
    input  wire logic                          startMission,
    input  wire logic                          stopMission,
    input  wire logic                          missionComplete,
    input  wire logic                          startOnAlarm,
    output logic                               startRefused_q,
    // Conversions
    input  wire logic                          sampleTick,
    input  wire logic                          minuteTick,
    input  wire logic                          conversionDone,
    input  wire logic                          conversionForced,
    input  wire logic [7:0]                    temperature,
    input  wire logic [7:0]                    lowThreshold,
    input  wire logic [7:0]                    highThreshold,
    output logic                               conversionRequest_q,
    output logic                               testConversion_q,
    // Calendar and mission state
    input  wire mission_status_pkg::stamp_type calendar,
    output logic                               missionActive_q,
    output logic [23:0]                        missionSampleCount_q
);
    mission_status_pkg::status_state_type s_q;
    mission_status_pkg::status_state_type s_d;

    logic        isLow;
    logic        isHigh;
    logic [23:0] delayValue;
    logic        delayZero;
    logic        delayWrite;
    logic        delayDecrement;
    logic [1:0]  delaySel;
    logic        clearOk;
    logic        startOk;
    logic        stopNow;
    logic        flagConv;
    logic        setLow;
    logic        setHigh;
    logic        alarmEvent;

    function automatic logic inRange(input logic [9:0] a,
                                     input logic [9:0] lo,
                                     input logic [9:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    function automatic mission_status_pkg::stamp_type maskStamp(
        input mission_status_pkg::stamp_type c);
        mission_status_pkg::stamp_type m;
        m.seconds = c.seconds & `MASK_SECONDS;
        m.minutes = c.minutes & `MASK_MINUTES;
        m.hours   = c.hours & `MASK_HOURS;
        m.date    = c.date & `MASK_DATE;
        m.month   = c.month & `MASK_MONTH;
        m.year    = c.year & `MASK_YEAR;
        maskStamp = m;
    endfunction : maskStamp

    function automatic logic [7:0] readMux(
        input logic [9:0]                        a,
        input mission_status_pkg::status_state_type st,
        input logic [23:0]                       dly);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `ADDR_ALARM_FLAGS:
            begin
                r = `ALARM_FIXED_VALUE;
                r[`BIT_LOW_ALARM]  = st.lowAlarm;
                r[`BIT_HIGH_ALARM] = st.highAlarm;
                r[`BIT_POWER_LOSS] = st.powerLoss;
            end
            `ADDR_GENERAL_STATUS:
            begin
                r = `STATUS_FIXED_VALUE;
                r[`BIT_MISSION_ACTIVE] = st.missionActive;
                r[`BIT_MEMORY_CLEARED] = st.memoryCleared;
                r[`BIT_AWAITING_ALARM] = st.awaitingAlarm;
            end
            `ADDR_DELAY_LOW:     r = dly[7:0];
            `ADDR_DELAY_MID:     r = dly[15:8];
            `ADDR_DELAY_HIGH:    r = dly[23:16];
            `ADDR_STAMP_SECONDS: r = st.stamp.seconds;
            `ADDR_STAMP_MINUTES: r = st.stamp.minutes;
            `ADDR_STAMP_HOURS:   r = st.stamp.hours;
            `ADDR_STAMP_DATE:    r = st.stamp.date;
            `ADDR_STAMP_MONTH:   r = st.stamp.month;
            `ADDR_STAMP_YEAR:    r = st.stamp.year;
            default: r = 8'h00;
        endcase
        readMux = r;
    endfunction : readMux

    alarm_compare compare (
        .temperature   (temperature),
        .lowThreshold  (lowThreshold),
        .highThreshold (highThreshold),
        .isLow         (isLow),
        .isHigh        (isHigh)
    );

    start_delay_counter delay (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .writeEn   (delayWrite),
        .byteSel   (delaySel),
        .writeData (writeData),
        .decrement (delayDecrement),
        .value     (delayValue),
        .isZero    (delayZero)
    );

    always_comb
    begin
        // Delay bytes lock for the whole mission, delay phase included
        delayWrite = writeStrobe && !s_q.missionActive
                     && inRange(address, `ADDR_DELAY_LOW, `ADDR_DELAY_HIGH);
        delaySel = 2'(address - `ADDR_DELAY_LOW);
        delayDecrement = (s_q.mode == mission_status_pkg::DELAY)
                         && minuteTick;
        // Clear memory during a mission would wipe live data, so it is ignored
        clearOk = clearMemory && !s_q.missionActive;
        startOk = startMission && !s_q.missionActive && s_q.memoryCleared;
        stopNow = (stopMission || missionComplete) && s_q.missionActive;
        // No conversions run while the delay counts down
        flagConv = conversionDone
                   && ((s_q.mode == mission_status_pkg::WAIT_ALARM)
                       || (s_q.mode == mission_status_pkg::LOGGING)
                       || (!s_q.missionActive && conversionForced));
        setLow = flagConv && isLow;
        setHigh = flagConv && isHigh;
        alarmEvent = setLow || setHigh;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.readValid = 1'b0;
        s_d.convRequest = 1'b0;
        s_d.testConversion = 1'b0;
        s_d.startRefused = 1'b0;
        if (readStrobe)
        begin
            s_d.readData = readMux(address, s_q, delayValue);
            s_d.readValid = 1'b1;
        end
        // A set in the same cycle as a clear wins
        s_d.lowAlarm = setLow || (s_q.lowAlarm && !clearOk);
        s_d.highAlarm = setHigh || (s_q.highAlarm && !clearOk);
        s_d.powerLoss = s_q.powerLoss && !clearOk;
        if (clearOk)
        begin
            s_d.memoryCleared = 1'b1;
            s_d.stamp = '0;
            s_d.sampleCount = 24'h00_0000;
        end
        if (startMission && !s_q.missionActive && !s_q.memoryCleared)
            s_d.startRefused = 1'b1;
        if (alarmEvent)
            s_d.awaitingAlarm = 1'b0;
        case (s_q.mode)
            mission_status_pkg::IDLE:
            begin
                if (startOk)
                begin
                    s_d.missionActive = 1'b1;
                    s_d.memoryCleared = 1'b0;
                    s_d.alarmMode = startOnAlarm;
                    s_d.firstDone = 1'b0;
                    if (startOnAlarm)
                        s_d.awaitingAlarm = 1'b1;
                    if (!delayZero)
                        s_d.mode = mission_status_pkg::DELAY;
                    else if (startOnAlarm)
                        s_d.mode = mission_status_pkg::WAIT_ALARM;
                    else
                        s_d.mode = mission_status_pkg::LOGGING;
                end
            end
            mission_status_pkg::DELAY:
            begin
                if (delayZero)
                begin
                    if (s_q.alarmMode)
                        s_d.mode = mission_status_pkg::WAIT_ALARM;
                    else
                        s_d.mode = mission_status_pkg::LOGGING;
                end
            end
            mission_status_pkg::WAIT_ALARM:
            begin
                if (sampleTick)
                begin
                    s_d.convRequest = 1'b1;
                    s_d.testConversion = 1'b1;
                end
                // The alarming test reading supplies the stamp but is not counted as a sample
                if (alarmEvent)
                begin
                    s_d.stamp = maskStamp(calendar);
                    s_d.firstDone = 1'b1;
                    s_d.mode = mission_status_pkg::LOGGING;
                end
            end
            mission_status_pkg::LOGGING:
            begin
                if (sampleTick)
                    s_d.convRequest = 1'b1;
                if (conversionDone)
                begin
                    s_d.sampleCount = s_q.sampleCount + 24'h00_0001;
                    if (!s_q.firstDone)
                    begin
                        s_d.stamp = maskStamp(calendar);
                        s_d.firstDone = 1'b1;
                    end
                end
            end
            default:
                s_d.mode = mission_status_pkg::IDLE;
        endcase
        if (stopNow)
        begin
            s_d.missionActive = 1'b0;
            s_d.mode = mission_status_pkg::IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.powerLoss <= `RESET_POWER_LOSS;
        end
        else if (ce)
            s_q <= s_d;
    end

    assign readData_q           = s_q.readData;
    assign readValid_q          = s_q.readValid;
    assign startRefused_q       = s_q.startRefused;
    assign conversionRequest_q  = s_q.convRequest;
    assign testConversion_q     = s_q.testConversion;
    assign missionActive_q      = s_q.missionActive;
    assign missionSampleCount_q = s_q.sampleCount;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    alarm_fixed_a: assert property (
        ce && readStrobe && address == `ADDR_ALARM_FLAGS
        |=> (readData_q & `ALARM_FIXED_MASK) == `ALARM_FIXED_VALUE && readValid_q)
        else $error("alarm flags fixed bits wrong");
    status_fixed_a: assert property (
        ce && readStrobe && address == `ADDR_GENERAL_STATUS
        |=> (readData_q & `STATUS_FIXED_MASK) == `STATUS_FIXED_VALUE
            && readData_q[`BIT_MISSION_ACTIVE] == $past(missionActive_q))
        else $error("general status fixed bits wrong");
    clear_alarms_a: assert property (
        ce && clearOk && !flagConv |=> !s_q.lowAlarm && !s_q.highAlarm && !s_q.powerLoss)
        else $error("clear memory left an alarm flag");
    low_alarm_a: assert property (
        ce && flagConv && temperature <= lowThreshold |=> s_q.lowAlarm)
        else $error("low alarm flag not set");
    high_alarm_a: assert property (
        ce && flagConv && temperature >= highThreshold |=> s_q.highAlarm)
        else $error("high alarm flag not set");
    stop_ends_a: assert property (
        ce && stopNow |=> !missionActive_q && s_q.mode == mission_status_pkg::IDLE)
        else $error("mission still active after stop");
    refuse_start_a: assert property (
        ce && startMission && !missionActive_q && !s_q.memoryCleared
        |=> startRefused_q && !missionActive_q)
        else $error("uncleared start not refused");
    start_clears_a: assert property (
        ce && startOk && !stopMission && !missionComplete
        |=> !s_q.memoryCleared && missionActive_q && !startRefused_q)
        else $error("start did not clear memory flag");
    delay_quiet_a: assert property (
        s_q.mode == mission_status_pkg::DELAY |=> !conversionRequest_q)
        else $error("conversion during start delay");
    delay_locked_a: assert property (
        ce && missionActive_q && s_q.mode != mission_status_pkg::DELAY
        |=> $stable(delayValue))
        else $error("delay changed during mission");

    // Delay bytes land only between missions, then count down by one
    delay_low_a: assert property (
        ce && writeStrobe && !missionActive_q && address == `ADDR_DELAY_LOW
        |=> delayValue[7:0] == $past(writeData))
        else $error("delay low byte not written");
    delay_high_a: assert property (
        ce && writeStrobe && !missionActive_q && address == `ADDR_DELAY_HIGH
        |=> delayValue[23:16] == $past(writeData))
        else $error("delay high byte not written");
    delay_count_a: assert property (
        ce && delayDecrement && !delayZero
        |=> delayValue == $past(delayValue) - 24'h00_0001)
        else $error("delay did not count down by one");
    delay_expire_a: assert property (
        ce && s_q.mode == mission_status_pkg::DELAY && delayZero && s_q.alarmMode && !stopNow
        |=> s_q.mode == mission_status_pkg::WAIT_ALARM)
        else $error("alarm testing did not follow the delay");

    // Power loss only goes away through clear memory
    power_held_a: assert property (
        ce && s_q.powerLoss && !clearOk |=> s_q.powerLoss)
        else $error("power loss alarm lost without clear");

    wait_set_a: assert property (
        ce && startOk && startOnAlarm |=> s_q.awaitingAlarm)
        else $error("awaiting alarm not set at start");
    wait_kept_a: assert property (
        ce && clearOk && s_q.awaitingAlarm && !alarmEvent |=> s_q.awaitingAlarm)
        else $error("clear memory dropped awaiting alarm");
    wait_cleared_a: assert property (
        ce && alarmEvent && !startOk |=> !s_q.awaitingAlarm)
        else $error("alarm left awaiting alarm set");

    test_request_a: assert property (
        ce && s_q.mode == mission_status_pkg::WAIT_ALARM && sampleTick
        |=> conversionRequest_q && testConversion_q)
        else $error("no test conversion while awaiting alarm");
    test_uncounted_a: assert property (
        ce && s_q.mode == mission_status_pkg::WAIT_ALARM
        |=> missionSampleCount_q == $past(missionSampleCount_q))
        else $error("test conversion was counted");
    count_cleared_a: assert property (
        ce && clearOk |=> missionSampleCount_q == 24'h00_0000)
        else $error("clear memory left the sample count");
    stamp_first_a: assert property (
        ce && s_q.mode == mission_status_pkg::LOGGING && conversionDone && !s_q.firstDone
        |=> s_q.stamp.year == $past(calendar.year) && s_q.firstDone)
        else $error("first sample time not captured");

    start_ok_c: cover property (ce && startOk);
    alarm_start_c: cover property (s_q.mode == mission_status_pkg::WAIT_ALARM
                                   && ce && alarmEvent);
    refused_c: cover property (startRefused_q);
    delay_run_c: cover property (ce && delayDecrement && !delayZero);
    wait_manual_c: cover property (ce && flagConv && conversionForced && s_q.awaitingAlarm);
endmodule : mission_status_registers
`default_nettype wire

/* File: verification/status_host_model.sv */
// Host side of the register port: single-byte reads and writes
// Assumes the bench calls its task from one process at a time
`timescale 1ns/10ps
`default_nettype none
module status_host_model (
    // Clock
    input  wire logic clk,
    // Register port requests
    output logic [9:0] address,
    output logic       readStrobe,
    output logic       writeStrobe,
    output logic [7:0] writeData
);
    initial
    begin
        address = 10'h000;
        readStrobe = 1'b0;
        writeStrobe = 1'b0;
        writeData = 8'h00;
    end
    // Request held over exactly one rising edge so it is taken once
    task automatic access(input logic [9:0] a, input logic wr, input logic [7:0] d);
        @(negedge clk);
        address = a;
        writeData = d;
        readStrobe = !wr;
        writeStrobe = wr;
        @(negedge clk);
        readStrobe = 1'b0;
        writeStrobe = 1'b0;
        // Released data must not keep showing the last byte
        writeData = ~d;
    endtask : access
endmodule : status_host_model
`default_nettype wire

/* File: verification/tb_mission_status_registers.sv */
// Self-checking bench of the mission status register bank
// Assumes the host model drives the register port; bench drives commands
`timescale 1ns/10ps
`default_nettype none
module tb_mission_status_registers;
    localparam int CLR = 0, START = 1, STOP = 2, DONE = 3, SAMPLE = 4, MINUTE = 5, CONV = 6;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] cmdBits = 7'h00;
    logic startOnAlarm = 1'b0;
    logic conversionForced = 1'b0;
    logic [7:0] temperature = 8'h80;
    logic [7:0] highThreshold = 8'hC0;
    mission_status_pkg::stamp_type calendar = 48'h5945_6331_9224;
    logic [9:0] address;
    logic readStrobe, writeStrobe, readValid_q, startRefused_q;
    logic conversionRequest_q, testConversion_q, missionActive_q;
    logic [7:0] writeData, readData_q;
    logic [23:0] missionSampleCount_q;
    logic [31:0] seed = 32'h0000_0009;
    logic [31:0] r;
    logic [7:0] expQ[$];
    logic [9:0] adrQ[$];
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    status_host_model status_host_model_i (.clk(clk), .address(address),
        .readStrobe(readStrobe), .writeStrobe(writeStrobe), .writeData(writeData));
    mission_status_registers mission_status_registers_i (.clk(clk), .reset(reset),
        .ce(1'b1), .address(address), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
        .writeData(writeData), .readData_q(readData_q), .readValid_q(readValid_q),
        .clearMemory(cmdBits[CLR]), .startMission(cmdBits[START]),
        .stopMission(cmdBits[STOP]), .missionComplete(cmdBits[DONE]),
        .startOnAlarm(startOnAlarm), .startRefused_q(startRefused_q),
        .sampleTick(cmdBits[SAMPLE]), .minuteTick(cmdBits[MINUTE]),
        .conversionDone(cmdBits[CONV]), .conversionForced(conversionForced),
        .temperature(temperature), .lowThreshold(8'h10), .highThreshold(highThreshold),
        .conversionRequest_q(conversionRequest_q), .testConversion_q(testConversion_q),
        .calendar(calendar), .missionActive_q(missionActive_q),
        .missionSampleCount_q(missionSampleCount_q));
    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nextRand
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic check_read(input logic [9:0] a, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD read %h expected %h seen %h", a, e, s);
        end
    endtask : check_read
    task automatic check_bit(input string name, input logic e, input logic s);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", name, e, s);
        end
    endtask : check_bit
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        adrQ.push_back(a);
        status_host_model_i.access(a, 1'b0, 8'h00);
    endtask : rd
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        status_host_model_i.access(a, 1'b1, d);
    endtask : wr
    // One-cycle command strobe; the edge between the two falling edges takes it
    task automatic pulse(input int k);
        @(negedge clk);
        cmdBits = 7'h01 << k;
        @(negedge clk);
        cmdBits = 7'h00;
    endtask : pulse
    task automatic waitHigh(input string name, ref logic sig);
        for (int i = 0; i < 8 && sig !== 1'b1; i++)
            @(negedge clk);
        check_bit(name, 1'b1, sig);
        if (sig !== 1'b1)
            close_out();
    endtask : waitHigh
    // Read answers are matched in order against the oldest note
    always @(negedge clk)
        if (readValid_q === 1'b1)
        begin
            if (expQ.size() == 0)
                check_bit("readValid", 1'b0, readValid_q);
            else
                check_read(adrQ.pop_front(), expQ.pop_front(), readData_q);
        end
    initial
    begin
        #200000;
        $display("BAD watchdog expected end seen hang");
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rd(10'h214, 8'hF0);
        rd(10'h215, 8'hC0);
        rd(10'h220, 8'h00);
        wr(10'h214, 8'h00);
        rd(10'h214, 8'hF0);
        r = nextRand();
        for (int b = 0; b < 3; b++)
            wr(10'h216 + 10'(b), r[8*b+:8]);
        for (int b = 0; b < 3; b++)
            rd(10'h216 + 10'(b), r[8*b+:8]);
        pulse(START);
        waitHigh("startRefused", startRefused_q);
        check_bit("missionActive", 1'b0, missionActive_q);
        $display("test reset, delay bytes and refused start done");
        pulse(CLR);
        rd(10'h215, 8'hC8);
        rd(10'h214, 8'h70);
        wr(10'h216, 8'h02);
        wr(10'h217, 8'h00);
        wr(10'h218, 8'h00);
        startOnAlarm = 1'b1;
        pulse(START);
        rd(10'h215, 8'hD2);
        wr(10'h216, 8'hFF);
        rd(10'h216, 8'h02);
        pulse(SAMPLE);
        // No test conversion may start while the delay still runs
        repeat (4)
        begin
            @(negedge clk);
            check_bit("conversionRequest", 1'b0, conversionRequest_q);
        end
        pulse(MINUTE);
        pulse(MINUTE);
        repeat (3) @(negedge clk);
        pulse(SAMPLE);
        waitHigh("conversionRequest", conversionRequest_q);
        check_bit("testConversion", 1'b1, testConversion_q);
        temperature = 8'hF0;
        pulse(CONV);
        rd(10'h214, 8'h72);
        rd(10'h215, 8'hC2);
        rd(10'h219, 8'h59);
        rd(10'h21B, 8'h63);
        rd(10'h21D, 8'h92);
        check_bit("sampleCount zero", 1'b1, missionSampleCount_q == 24'h00_0000);
        pulse(STOP);
        check_bit("missionActive", 1'b0, missionActive_q);
        $display("test delayed start on alarm done");
        startOnAlarm = 1'b0;
        pulse(CLR);
        rd(10'h214, 8'h70);
        for (int b = 0; b < 3; b++)
            wr(10'h216 + 10'(b), 8'h00);
        pulse(START);
        pulse(SAMPLE);
        waitHigh("conversionRequest", conversionRequest_q);
        check_bit("testConversion", 1'b0, testConversion_q);
        temperature = 8'h10;
        pulse(CONV);
        rd(10'h214, 8'h71);
        check_bit("sampleCount one", 1'b1, missionSampleCount_q == 24'h00_0001);
        pulse(DONE);
        check_bit("missionActive", 1'b0, missionActive_q);
        temperature = 8'hF0;
        conversionForced = 1'b1;
        pulse(CONV);
        conversionForced = 1'b0;
        rd(10'h214, 8'h73);
        pulse(CLR);
        rd(10'h214, 8'h70);
        rd(10'h219, 8'h00);
        check_bit("sampleCount zero", 1'b1, missionSampleCount_q == 24'h00_0000);
        startOnAlarm = 1'b1;
        pulse(START);
        pulse(STOP);
        rd(10'h215, 8'hD0);
        pulse(CLR);
        rd(10'h215, 8'hD8);
        // Lowest high threshold makes any forced reading alarm
        highThreshold = 8'h00;
        temperature = 8'h80;
        conversionForced = 1'b1;
        pulse(CONV);
        conversionForced = 1'b0;
        highThreshold = 8'hC0;
        rd(10'h215, 8'hC8);
        rd(10'h214, 8'h72);
        $display("test manual awaiting alarm clear done");
        repeat (4) @(negedge clk);
        check_bit("all reads answered", 1'b1, expQ.size() == 0);
        $display("test plain mission and forced conversion done");
        close_out();
    end
endmodule : tb_mission_status_registers
`default_nettype wire
